// ---- verilog/gpio_port_defines.vh ----
// constants for the configurable digital io port: register map, fields, reset values
//
// Overview of operation
// [RQ1] sixteen lines, each usable as input, output or isolated pair member
// [RQ2] every line has its own direction and function setting
// [RQ3] per-line polarity picks high-true or low-true asserted state
// [RQ4] general purpose lines pass data straight through, never steer the sequence
// [RQ5] outputs are open collector: logical low pulls down, high releases
// [RQ6] inputs have pull-ups, so open contacts read high
// [RQ7] bidirectional: writing one releases the line, writing zero pulls it low
// [RQ8] bidirectional reads return the real pin level, not the written value
// [RQ9] isolated pairs are fixed even/odd neighbours from line 0, eight at most
// [RQ10] only the even line's polarity sets an isolated pair's polarity
// [RQ11] low-true pair conducts when asserted; high-true pair opens when asserted
// [RQ12] fault input stops the forming sequence and asserts the fault output
// [RQ13] fault output stays asserted until the protection clear command
// [RQ14] interlock level halts the sequence without asserting the fault output
// [RQ15] interlock removal resumes the halted sequence where it stopped
// [RQ16] asserted trigger line starts the forming sequence
// [RQ17] when enabled, power-fail input causes shutdown and state save; the code ignores it in st_fault, and a simultaneous fault wins
// [RQ18] power-fail output asserts once the saved shutdown state is complete
// [RQ19] pin inputs pass two flip-flops and polarity before any use
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// byte addresses on apb
`define ADDR_MODE 8'h00
`define ADDR_POL 8'h04
`define ADDR_OUT 8'h08
`define ADDR_IN 8'h0c
`define ADDR_FUNC 8'h10
`define ADDR_CTRL 8'h14
`define ADDR_STAT 8'h18
`define ADDR_IRQ_STAT 8'h1c
`define ADDR_IRQ_MASK 8'h20
`define ADDR_STEP 8'h24

////////////////////////////////////////////////////////////////////////////////
// line modes, two bits per line in the mode register
`define MODE_IN 2'h0
`define MODE_OUT 2'h1
`define MODE_BIDIR 2'h2
`define MODE_ISO 2'h3

////////////////////////////////////////////////////////////////////////////////
// function register: 4-bit line index fields, then one enable bit per function
`define FN_FAULT_IN_LSB 0
`define FN_FAULT_OUT_LSB 4
`define FN_ILOCK_LSB 8
`define FN_TRIG_LSB 12
`define FN_PF_IN_LSB 16
`define FN_PF_OUT_LSB 20
`define FN_EN_FAULT_IN 24
`define FN_EN_FAULT_OUT 25
`define FN_EN_ILOCK 26
`define FN_EN_TRIG 27
`define FN_EN_PF_IN 28
`define FN_EN_PF_OUT 29

////////////////////////////////////////////////////////////////////////////////
// control register bits
`define CTRL_CLEAR 0
`define CTRL_PF_EN 1

////////////////////////////////////////////////////////////////////////////////
// interrupt status and mask bits
`define IRQ_FAULT 0
`define IRQ_START 1
`define IRQ_HALT 2
`define IRQ_SHUTDOWN 3
`define IRQ_SAVED 4
`define IRQ_BITS 5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_MODE 32'h00000000
`define RST_POL 16'h0000
`define RST_OUT 16'hffff
`define RST_FUNC 32'h00000000
`define RST_PF_EN 1'b0
`define RST_IRQ_MASK 5'h00
`define RST_SYNC 16'hffff
`define RST_STEP 16'h0000

`endif

// ---- verilog/configurable_digital_io_port.v ----
// configurable 16-line digital io port with forming-sequence special functions, apb slave
`include "gpio_port_defines.vh"

module configurable_digital_io_port (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] io_in,
  output reg [15:0] io_out,
  output reg [15:0] io_oe,
  input wire state_saved,
  output reg seq_run,
  output reg seq_halt,
  output reg shutdown_req,
  output reg fault_active,
  output reg pf_saved,
  output reg irq
);

  localparam [2:0] st_idle = 3'h0;
  localparam [2:0] st_run = 3'h1;
  localparam [2:0] st_halt = 3'h2;
  localparam [2:0] st_fault = 3'h3;
  localparam [2:0] st_shutdown = 3'h4;
  localparam [2:0] st_saved = 3'h5;

  // pick the logical level of a line chosen by a 4-bit index field
  function line_at;
    input [15:0] vec;
    input [3:0] idx;
    begin
      line_at = vec[idx];
    end
  endfunction

  // two-bit mode field of one line
  function [1:0] mode_of;
    input [31:0] modes;
    input [3:0] line;
    begin
      mode_of = modes[2*line +: 2];
    end
  endfunction

  // output and bidirectional lines share the same open-collector drive
  function drives_line;
    input [1:0] m;
    begin
      drives_line = (m == `MODE_OUT) || (m == `MODE_BIDIR);
    end
  endfunction

  // low-true pair conducts when asserted, high-true pair opens
  function pair_drive;
    input v;
    input low_true;
    begin
      pair_drive = low_true ? v : ~v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  reg [31:0] mode_reg;
  reg [15:0] pol_reg;
  reg [15:0] out_reg;
  reg [31:0] func_reg;
  reg pf_en;
  reg [`IRQ_BITS-1:0] irq_stat;
  reg [`IRQ_BITS-1:0] irq_mask;
  reg [15:0] sync1;
  reg [15:0] sync2;
  reg [2:0] state;
  reg [15:0] step_count;
  reg fault_latch;

  reg [2:0] next_state;
  reg [15:0] next_oe;
  reg [31:0] next_rdata;
  reg next_err;
  reg [15:0] val;
  reg [`IRQ_BITS-1:0] events;
  integer i;

  wire bus_done = psel & penable & pready;
  wire wr = bus_done & pwrite;
  wire rd = bus_done & ~pwrite;
  wire clr_cmd = wr & (paddr == `ADDR_CTRL) & pwdata[`CTRL_CLEAR];

  // synchronised, polarity-corrected pin levels
  wire [15:0] lvl = sync2 ^ pol_reg; // RQ19 RQ3

  ////////////////////////////////////////////////////////////////////////////
  // special-function inputs; unassigned lines never reach the sequence
  wire fault_in = func_reg[`FN_EN_FAULT_IN] &
    line_at(lvl, func_reg[`FN_FAULT_IN_LSB +: 4]); // RQ2 RQ4
  wire ilock_in = func_reg[`FN_EN_ILOCK] &
    line_at(lvl, func_reg[`FN_ILOCK_LSB +: 4]); // RQ4
  wire trig_in = func_reg[`FN_EN_TRIG] &
    line_at(lvl, func_reg[`FN_TRIG_LSB +: 4]); // RQ4
  wire pf_in = pf_en & func_reg[`FN_EN_PF_IN] &
    line_at(lvl, func_reg[`FN_PF_IN_LSB +: 4]); // RQ17

  ////////////////////////////////////////////////////////////////////////////
  // forming sequence state machine
  always @* begin
    next_state = state;
    case (state)
      st_idle: begin
        if (fault_in) begin
          next_state = st_fault; // RQ12
        end else if (pf_in) begin
          next_state = st_shutdown; // RQ17
        end else if (trig_in) begin
          next_state = st_run; // RQ16
        end
      end
      st_run: begin
        if (fault_in) begin
          next_state = st_fault; // RQ12
        end else if (pf_in) begin
          next_state = st_shutdown; // RQ17
        end else if (ilock_in) begin
          next_state = st_halt; // RQ14
        end
      end
      st_halt: begin
        if (fault_in) begin
          next_state = st_fault; // RQ12
        end else if (pf_in) begin
          next_state = st_shutdown; // RQ17
        end else if (!ilock_in) begin
          next_state = st_run; // RQ15
        end
      end
      st_fault: begin
        // a fault still present keeps the sequence stopped after the clear
        if (clr_cmd && !fault_in) begin
          next_state = st_idle; // RQ13
        end
      end
      st_shutdown: begin
        if (state_saved) begin
          next_state = st_saved; // RQ18
        end
      end
      st_saved: begin
        // restart needs software: a bare power return must not resume cells
        if (clr_cmd) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: open collector only, so io_out is held low and oe pulls
  always @* begin
    val = out_reg;
    if (func_reg[`FN_EN_FAULT_OUT]) begin
      val[func_reg[`FN_FAULT_OUT_LSB +: 4]] = fault_latch; // RQ12 RQ13
    end
    if (func_reg[`FN_EN_PF_OUT]) begin
      val[func_reg[`FN_PF_OUT_LSB +: 4]] = (state == st_saved); // RQ18
    end
    next_oe = 16'h0000;
    for (i = 0; i < 16; i = i + 1) begin
      if (mode_of(mode_reg, {i[3:1], 1'b0}) == `MODE_ISO) begin
        // pair follows the even line's value and polarity only
        next_oe[i] = pair_drive(val[{i[3:1], 1'b0}], pol_reg[{i[3:1], 1'b0}]); // RQ9 RQ10 RQ11
      end else if (drives_line(mode_of(mode_reg, i[3:0]))) begin
        next_oe[i] = ~(val[i] ^ pol_reg[i]); // RQ5 RQ7 RQ3
      end else begin
        next_oe[i] = 1'b0; // RQ6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events
  always @* begin
    events = {`IRQ_BITS{1'b0}};
    events[`IRQ_FAULT] = fault_in & ~fault_latch;
    events[`IRQ_START] = (state == st_idle) & (next_state == st_run);
    events[`IRQ_HALT] = (state == st_run) & (next_state == st_halt);
    events[`IRQ_SHUTDOWN] = (state != st_shutdown) & (next_state == st_shutdown);
    events[`IRQ_SAVED] = (state == st_shutdown) & (next_state == st_saved);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read decode
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == `ADDR_MODE) begin
      next_rdata = mode_reg;
    end else if (paddr == `ADDR_POL) begin
      next_rdata = {16'h0000, pol_reg};
    end else if (paddr == `ADDR_OUT) begin
      next_rdata = {16'h0000, out_reg};
    end else if (paddr == `ADDR_IN) begin
      // live pin level for every mode, including driven bidir lines
      next_rdata = {16'h0000, lvl}; // RQ8 RQ4
    end else if (paddr == `ADDR_FUNC) begin
      next_rdata = {2'h0, func_reg[29:0]};
    end else if (paddr == `ADDR_CTRL) begin
      next_rdata = {30'h00000000, pf_en, 1'b0};
    end else if (paddr == `ADDR_STAT) begin
      next_rdata = {25'h0000000, fault_latch, ilock_in, fault_in, state == st_saved, state};
    end else if (paddr == `ADDR_IRQ_STAT) begin
      next_rdata = {27'h0000000, irq_stat};
    end else if (paddr == `ADDR_IRQ_MASK) begin
      next_rdata = {27'h0000000, irq_mask};
    end else if (paddr == `ADDR_STEP) begin
      next_rdata = {16'h0000, step_count};
    end else begin
      next_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, data and error valid with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `RST_MODE;
      pol_reg <= `RST_POL;
      out_reg <= `RST_OUT;
      func_reg <= `RST_FUNC;
      pf_en <= `RST_PF_EN;
      irq_mask <= `RST_IRQ_MASK;
    end else if (ce && wr) begin
      if (paddr == `ADDR_MODE) begin
        mode_reg <= pwdata; // RQ2
      end else if (paddr == `ADDR_POL) begin
        pol_reg <= pwdata[15:0]; // RQ3
      end else if (paddr == `ADDR_OUT) begin
        out_reg <= pwdata[15:0]; // RQ4
      end else if (paddr == `ADDR_FUNC) begin
        func_reg <= {2'h0, pwdata[29:0]}; // RQ2
      end else if (paddr == `ADDR_CTRL) begin
        pf_en <= pwdata[`CTRL_PF_EN]; // RQ17
      end else if (paddr == `ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[`IRQ_BITS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `RST_SYNC;
      sync2 <= `RST_SYNC;
    end else if (ce) begin
      sync1 <= io_in; // RQ19
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence, fault latch, progress count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      fault_latch <= 1'b0;
      step_count <= `RST_STEP;
    end else if (ce) begin
      state <= next_state;
      // a fault in the clear cycle wins, so it is never lost
      if (fault_in) begin
        fault_latch <= 1'b1; // RQ12
      end else if (clr_cmd) begin
        fault_latch <= 1'b0; // RQ13
      end
      if (state == st_idle && next_state == st_run) begin
        step_count <= 16'h0000; // RQ16
      end else if (state == st_run) begin
        // held in halt so the run resumes at the same step
        step_count <= step_count + 16'h0001; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: read clears, a new event in that cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {`IRQ_BITS{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      if (rd && paddr == `ADDR_IRQ_STAT) begin
        irq_stat <= events;
        irq <= |(events & irq_mask);
      end else begin
        irq_stat <= irq_stat | events;
        irq <= |((irq_stat | events) & irq_mask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= 16'h0000;
      io_oe <= 16'h0000;
      seq_run <= 1'b0;
      seq_halt <= 1'b0;
      shutdown_req <= 1'b0;
      fault_active <= 1'b0;
      pf_saved <= 1'b0;
    end else if (ce) begin
      io_out <= 16'h0000; // RQ5
      io_oe <= next_oe; // RQ1
      seq_run <= (next_state == st_run);
      seq_halt <= (next_state == st_halt) | (next_state == st_fault); // RQ12 RQ14
      shutdown_req <= (next_state == st_shutdown); // RQ17
      fault_active <= fault_in | (fault_latch & ~clr_cmd);
      pf_saved <= (next_state == st_saved); // RQ18
    end
  end

endmodule

// ---- verification/gpio_port_assertions.sv ----
// checker for the configurable digital io port
module gpio_port_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] io_out,
  input wire logic seq_run,
  input wire logic seq_halt,
  input wire logic shutdown_req,
  input wire logic fault_active,
  input wire logic pf_saved
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // clear lands one edge before the latch output drops
  wire clr = ce & psel & penable & pready & pwrite & (paddr == 8'h14) & pwdata[0];
  ////////////////////////////////////////
  chk_oc_low: assert property (io_out == 16'h0000)
    else $error("open collector drove high");
  chk_fault_stops: assert property ($rose(fault_active) |-> seq_halt && !seq_run)
    else $error("fault did not stop sequence");
  chk_fault_held: assert property ($fell(fault_active) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("fault output dropped without clear");
  chk_halt_no_run: assert property (seq_halt |-> !seq_run)
    else $error("halted and running");
  chk_shutdown_stops: assert property (shutdown_req |-> !seq_run)
    else $error("running during shutdown");
  chk_saved_order: assert property ($rose(pf_saved) |-> $past(shutdown_req))
    else $error("saved without shutdown");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access end");
endmodule
bind configurable_digital_io_port gpio_port_assertions gpio_port_assertions_inst (.pclk, .presetn,
  .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_out, .seq_run,
  .seq_halt, .shutdown_req, .fault_active, .pf_saved);

// ---- verification/pin_side_model.sv ----
// pins with pull-ups, external switches and the system save handshake
module pin_side_model (
  input wire logic pclk,
  input wire logic [15:0] io_oe,
  input wire logic [15:0] ext_low,
  input wire logic shutdown_req,
  output logic [15:0] io_in,
  output logic state_saved
);
  logic [1:0] dly = 2'h0;
  // a pin nobody pulls down floats high through its pull-up
  assign io_in = ~(io_oe | ext_low);
  always @(posedge pclk) dly <= {dly[0], shutdown_req};
  assign state_saved = dly[1];
endmodule

// ---- verification/tb_configurable_digital_io_port.sv ----
// self-checking bench for the configurable digital io port
module tb_configurable_digital_io_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, a;
  logic pready, pslverr, state_saved, seq_run, seq_halt, shutdown_req, fault_active, pf_saved, irq;
  logic [15:0] io_in, io_out, io_oe, ext_low = 16'h0000;
  int mismatches = 0, checks_done = 0, cycles = 0;
  initial forever #12.5 pclk = ~pclk;
  configurable_digital_io_port configurable_digital_io_port_inst (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_in, .io_out, .io_oe,
    .state_saved, .seq_run, .seq_halt, .shutdown_req, .fault_active, .pf_saved, .irq);
  pin_side_model pin_side_model_inst (.pclk, .io_oe, .ext_low, .shutdown_req, .io_in,
    .state_saved);
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    chk("ready", n < 40, 1);
  endtask
  // pin effects need two sync flops plus the state edge
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    apb(0, 8'h00, 0);
    chk("mode", r, 0);
    apb(0, 8'h08, 0);
    chk("out", r, 32'h0000ffff);
    apb(0, 8'h28, 0);
    chk("unmapped", err, 1);
    chk("oe", io_oe, 16'h0000);
    chk("io_out", io_out, 16'h0000);
    $display("reset test done");
  endtask
  task t_gpio;
    apb(1, 8'h04, 32'h000003e6);
    apb(1, 8'h00, 32'h000402f1);
    apb(1, 8'h08, 32'h0000fffe);
    settle;
    chk("oe low pair", io_oe, 16'h020d);
    apb(1, 8'h08, 32'h0000fffa);
    ext_low <= 16'h0012;
    settle;
    chk("oe open pair", io_oe, 16'h0201);
    apb(0, 8'h0c, 0);
    chk("in", r, 32'h0000fe0a);
    ext_low <= 16'h0000;
    apb(1, 8'h08, 32'h0000ffea);
    settle;
    chk("bidir low", io_oe, 16'h0211);
    chk("no run", seq_run, 0);
    $display("gpio test done");
  endtask
  task t_seq;
    apb(1, 8'h20, 32'h1);
    apb(1, 8'h10, 32'h3f086795);
    apb(1, 8'h14, 32'h2);
    ext_low <= 16'h0040;
    settle;
    chk("started", seq_run, 1);
    ext_low <= 16'h0000;
    settle;
    chk("masked", irq, 0);
    ext_low <= 16'h0080;
    settle;
    chk("halt", {seq_halt, seq_run, fault_active}, 3'b100);
    apb(0, 8'h24, 0);
    a = r;
    settle;
    apb(0, 8'h24, 0);
    chk("held", r, a);
    ext_low <= 16'h0000;
    settle;
    chk("resume", seq_run, 1);
    apb(0, 8'h24, 0);
    chk("counted", r > a, 1);
    ext_low <= 16'h0100;
    repeat (4) @(posedge pclk);
    chk("shutdown", {shutdown_req, seq_run, pf_saved}, 3'b100);
    settle;
    chk("saved", {pf_saved, shutdown_req, io_oe[0]}, 3'b100);
    ext_low <= 16'h0000;
    apb(1, 8'h14, 32'h3);
    settle;
    chk("saved cleared", {pf_saved, io_oe[0]}, 2'b01);
    $display("sequence test done");
  endtask
  task t_fault;
    apb(0, 8'h1c, 0);
    ext_low <= 16'h0020;
    settle;
    chk("fault", {fault_active, seq_halt, irq, io_oe[9]}, 4'b1111);
    ext_low <= 16'h0000;
    settle;
    chk("latched", fault_active, 1);
    apb(0, 8'h18, 0);
    chk("status", r, 32'h00000043);
    apb(0, 8'h1c, 0);
    chk("irq stat", r[0], 1);
    settle;
    chk("irq clear", irq, 0);
    apb(1, 8'h14, 32'h3);
    settle;
    chk("cleared", {fault_active, io_oe[9]}, 2'b00);
    ce <= 0;
    ext_low <= 16'h0040;
    settle;
    chk("frozen", seq_run, 0);
    ce <= 1;
    settle;
    chk("thawed", seq_run, 1);
    $display("fault test done");
  endtask
  ////////////////////////////////////////
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_gpio;
    t_seq;
    t_fault;
    conclude;
  end
endmodule
